// File: pkg/fwps_cfg.svh
`ifndef FWPS_CFG_SVH
`define FWPS_CFG_SVH

// Register byte addresses on the Wishbone bus (one 32-bit word each).
`define FWPS_ADDR_PTR_UPPER 6'h00
`define FWPS_ADDR_PTR_HIGH 6'h04
`define FWPS_ADDR_PTR_LOW 6'h08
`define FWPS_ADDR_LATCH 6'h0c
`define FWPS_ADDR_IRQ_CTRL 6'h10
`define FWPS_ADDR_UNLOCK 6'h14
`define FWPS_ADDR_CONTROL 6'h18
`define FWPS_ADDR_HOLD 6'h1c
`define FWPS_ADDR_TABLE_WRITE 6'h20
`define FWPS_ADDR_STATUS 6'h24
`define FWPS_ADDR_MASK 6'h28

// Flash control field positions.
`define FWPS_BIT_START 1
`define FWPS_BIT_WR_ENABLE 2
`define FWPS_BIT_WR_ERROR 3
`define FWPS_BIT_WORD_ENABLE 5
`define FWPS_CONTROL_MASK 8'h3e

// Table-write register field positions.
`define FWPS_BIT_TABLE_INC 0

// Interrupt control: only the global enable is kept.
`define FWPS_BIT_IRQ_ENABLE 7

// Event status bit positions.
`define FWPS_EV_DONE 0
`define FWPS_EV_REFUSED 1

// Key values for the unlock register.
`define FWPS_KEY1 8'h55
`define FWPS_KEY2 8'haa

// Reset values.
`define FWPS_RST_BYTE 8'h00
`define FWPS_RST_PTR 21'h000000

// Word write time in microseconds and its cycle count at 25 MHz.
`define FWPS_CLK_MHZ 25
`define FWPS_TIW_US 2800
`define FWPS_TIW_CYCLES (`FWPS_TIW_US * `FWPS_CLK_MHZ)

`endif

// File: pkg/fwps_pkg.sv
package fwps_pkg;
    typedef enum logic [1:0] {
        FWPS_KEY_IDLE = 2'b00,
        FWPS_KEY_HALF = 2'b01,
        FWPS_KEY_OPEN = 2'b10
    } fwps_key_t;

    typedef enum logic [1:0] {
        FWPS_ST_IDLE = 2'b00,
        FWPS_ST_WRITE = 2'b01,
        FWPS_ST_DONE = 2'b10
    } fwps_state_t;
endpackage

// File: rtl/fwps_timer.sv
`timescale 1ns/1ps
`include "fwps_cfg.svh"

module fwps_timer
    import fwps_pkg::*;
#(
    parameter int unsigned CYCLES = `FWPS_TIW_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    output logic done_o
);
    logic [31:0] count_reg;
    logic running_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= 32'h0;
            running_reg <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !running_reg) begin
                count_reg <= 32'h1;
                running_reg <= 1'b1;
            end else if (running_reg) begin
                if (count_reg >= CYCLES) begin
                    running_reg <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count_reg <= count_reg + 32'h1;
                end
            end
        end
    end
endmodule

// File: rtl/fwps_sequencer.sv
// Function
// - A word program happens only while the single word enable bit is set.
// - Write enable bit two must be set; the device refuses programming otherwise.
// - Start is accepted only after key writes 0x55 then 0xaa.
// - Setting start after a valid unlock begins the flash write cycle.
// - Instruction execution stalls for the whole word write.
// - A write cut by master clear or watchdog reset sets the error flag.
// - The table pointer spans upper 20:16, high 15:8 and low 7:0 bytes.
// - The unlock register has no storage; writes only feed the key detector.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "fwps_cfg.svh"

module fwps_sequencer
    import fwps_pkg::*;
#(
    parameter int unsigned TIW_CYCLES = `FWPS_TIW_CYCLES
) (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_clear_reset_i,
    input wire logic wdt_rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Flash array write port
    output logic flash_we_o,
    output logic [20:0] flash_addr_o,
    output logic [15:0] flash_data_o,
    // Core and interrupt
    output logic cpu_stall_o,
    output logic irq_o
);
    logic [1:0] master_clear_sync_reg;
    logic [1:0] wdt_sync_reg;
    logic [4:0] ptr_upper_reg;
    logic [7:0] ptr_high_reg;
    logic [7:0] ptr_low_reg;
    logic [7:0] latch_reg;
    logic [7:0] hold_lo_reg;
    logic [7:0] hold_hi_reg;
    logic irq_enable_reg;
    logic word_enable_reg;
    logic write_enable_reg;
    logic start_reg;
    logic write_error_reg;
    logic [1:0] status_reg;
    logic [1:0] mask_reg;
    fwps_key_t key_reg;
    fwps_state_t state_reg;
    logic timer_go;
    logic timer_done;
    logic wr_stb;
    logic rd_stb;
    logic start_req;
    logic refuse_ev;
    logic done_ev;
    logic ext_rst;
    logic [20:0] ptr;
    logic [7:0] rd_byte;

    assign wr_stb = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
    assign rd_stb = cyc_i && stb_i && !we_i && !ack_o;
    assign ptr = {ptr_upper_reg, ptr_high_reg, ptr_low_reg};
    assign ext_rst = master_clear_sync_reg[1] || wdt_sync_reg[1];
    assign start_req = wr_stb && adr_i == `FWPS_ADDR_CONTROL && dat_i[`FWPS_BIT_START] && state_reg == FWPS_ST_IDLE;
    // The start only takes effect with both enables set and the key open.
    assign timer_go = start_req && key_reg == FWPS_KEY_OPEN && word_enable_reg && write_enable_reg;
    assign refuse_ev = start_req && !timer_go;
    assign done_ev = timer_done;

    // External resets arrive asynchronously and are synchronised first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            master_clear_sync_reg <= 2'b00;
            wdt_sync_reg <= 2'b00;
        end else begin
            master_clear_sync_reg <= {master_clear_sync_reg[0], master_clear_reset_i};
            wdt_sync_reg <= {wdt_sync_reg[0], wdt_rst_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    always_comb begin
        rd_byte = `FWPS_RST_BYTE;
        unique case (adr_i)
            `FWPS_ADDR_PTR_UPPER: rd_byte = {3'h0, ptr_upper_reg};
            `FWPS_ADDR_PTR_HIGH: rd_byte = ptr_high_reg;
            `FWPS_ADDR_PTR_LOW: rd_byte = ptr_low_reg;
            `FWPS_ADDR_LATCH: rd_byte = latch_reg;
            `FWPS_ADDR_IRQ_CTRL: rd_byte = {irq_enable_reg, 7'h00};
            `FWPS_ADDR_CONTROL: rd_byte = {2'b00, word_enable_reg, 1'b0, write_error_reg, write_enable_reg, start_reg, 1'b0};
            `FWPS_ADDR_HOLD: rd_byte = hold_lo_reg;
            `FWPS_ADDR_STATUS: rd_byte = {6'h00, status_reg};
            `FWPS_ADDR_MASK: rd_byte = {6'h00, mask_reg};
            default: rd_byte = `FWPS_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0;
        end else if (rd_stb) begin
            dat_o <= {24'h0, rd_byte};
        end
    end

    // Table pointer, latch and table writes into the holding bytes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_upper_reg <= 5'h00;
            ptr_high_reg <= `FWPS_RST_BYTE;
            ptr_low_reg <= `FWPS_RST_BYTE;
            latch_reg <= `FWPS_RST_BYTE;
            hold_lo_reg <= `FWPS_RST_BYTE;
            hold_hi_reg <= `FWPS_RST_BYTE;
        end else if (wr_stb && state_reg == FWPS_ST_IDLE) begin
            unique case (adr_i)
                `FWPS_ADDR_PTR_UPPER: ptr_upper_reg <= dat_i[4:0];
                `FWPS_ADDR_PTR_HIGH: ptr_high_reg <= dat_i[7:0];
                `FWPS_ADDR_PTR_LOW: ptr_low_reg <= dat_i[7:0];
                `FWPS_ADDR_LATCH: latch_reg <= dat_i[7:0];
                `FWPS_ADDR_TABLE_WRITE: begin
                    // The pointer's low bit picks the byte of the word.
                    if (ptr_low_reg[0]) begin
                        hold_hi_reg <= latch_reg;
                    end else begin
                        hold_lo_reg <= latch_reg;
                    end
                    if (dat_i[`FWPS_BIT_TABLE_INC]) begin
                        {ptr_upper_reg, ptr_high_reg, ptr_low_reg} <= ptr + 21'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Only the unlock detector sees writes to the key address.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_reg <= FWPS_KEY_IDLE;
        end else if (wr_stb && adr_i != `FWPS_ADDR_UNLOCK) begin
            // Any other write breaks the sequence, start attempts included.
            key_reg <= FWPS_KEY_IDLE;
        end else if (wr_stb) begin
            unique case (key_reg)
                FWPS_KEY_IDLE: begin
                    if (dat_i[7:0] == `FWPS_KEY1) begin
                        key_reg <= FWPS_KEY_HALF;
                    end
                end
                FWPS_KEY_HALF: begin
                    if (dat_i[7:0] == `FWPS_KEY2) begin
                        key_reg <= FWPS_KEY_OPEN;
                    end else if (dat_i[7:0] != `FWPS_KEY1) begin
                        key_reg <= FWPS_KEY_IDLE;
                    end
                end
                FWPS_KEY_OPEN: begin
                    // A further key write restarts the sequence rather than keeping the lock open.
                    if (dat_i[7:0] == `FWPS_KEY1) begin
                        key_reg <= FWPS_KEY_HALF;
                    end else begin
                        key_reg <= FWPS_KEY_IDLE;
                    end
                end
                default: begin
                    key_reg <= FWPS_KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_enable_reg <= 1'b0;
            word_enable_reg <= 1'b0;
            write_enable_reg <= 1'b0;
            mask_reg <= 2'b00;
        end else if (wr_stb) begin
            if (adr_i == `FWPS_ADDR_IRQ_CTRL) begin
                irq_enable_reg <= dat_i[`FWPS_BIT_IRQ_ENABLE];
            end
            if (adr_i == `FWPS_ADDR_CONTROL) begin
                word_enable_reg <= dat_i[`FWPS_BIT_WORD_ENABLE];
                write_enable_reg <= dat_i[`FWPS_BIT_WR_ENABLE];
            end
            if (adr_i == `FWPS_ADDR_MASK) begin
                mask_reg <= dat_i[1:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= FWPS_ST_IDLE;
            start_reg <= 1'b0;
            cpu_stall_o <= 1'b0;
        end else begin
            unique case (state_reg)
                FWPS_ST_IDLE: begin
                    if (timer_go) begin
                        state_reg <= FWPS_ST_WRITE;
                        start_reg <= 1'b1;
                        cpu_stall_o <= 1'b1;
                    end
                end
                FWPS_ST_WRITE: begin
                    if (ext_rst) begin
                        state_reg <= FWPS_ST_IDLE;
                        start_reg <= 1'b0;
                        cpu_stall_o <= 1'b0;
                    end else if (timer_done) begin
                        state_reg <= FWPS_ST_DONE;
                        start_reg <= 1'b0;
                        cpu_stall_o <= 1'b0;
                    end
                end
                FWPS_ST_DONE: begin
                    state_reg <= FWPS_ST_IDLE;
                end
                default: begin
                    state_reg <= FWPS_ST_IDLE;
                end
            endcase
        end
    end

    // The core reset sets the error flag if it cuts a write and clears it in any other state, so only a one-cycle reset leaves it set.
    always_ff @(posedge clk_i) begin
        if (rst_i && state_reg != FWPS_ST_WRITE) begin
            write_error_reg <= 1'b0;
        end else if ((ext_rst || rst_i) && state_reg == FWPS_ST_WRITE) begin
            write_error_reg <= 1'b1;
        end else if (wr_stb && adr_i == `FWPS_ADDR_CONTROL && !dat_i[`FWPS_BIT_WR_ERROR]) begin
            write_error_reg <= 1'b0;
        end
    end

    // The array sees one write pulse when the cycle ends.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_we_o <= 1'b0;
            flash_addr_o <= `FWPS_RST_PTR;
            flash_data_o <= 16'h0000;
        end else begin
            flash_we_o <= timer_done && state_reg == FWPS_ST_WRITE && !ext_rst;
            if (timer_go) begin
                flash_addr_o <= {ptr[20:1], 1'b0};
                flash_data_o <= {hold_hi_reg, hold_lo_reg};
            end
        end
    end

    // Events set sticky bits; set wins over the clear by a status read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= 2'b00;
        end else begin
            status_reg <= (rd_stb && adr_i == `FWPS_ADDR_STATUS ? 2'b00 : status_reg) | {refuse_ev, done_ev};
        end
    end

    // The request line trails the status by one cycle so that it comes straight from a flip-flop.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_reg & mask_reg);
        end
    end

    fwps_timer #(
        .CYCLES(TIW_CYCLES)
    ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i || ext_rst),
        .start_i(timer_go),
        .done_o(timer_done)
    );
endmodule

// File: verification/fwps_sequencer_assertions.sv
`timescale 1ns/1ps
`include "fwps_cfg.svh"

module fwps_sequencer_assertions #(
    parameter int unsigned TIW_CYCLES = 20
) (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic master_clear_reset_i,
    // Wishbone
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Flash and core
    input wire logic flash_we_o,
    input wire logic [20:0] flash_addr_o,
    input wire logic cpu_stall_o,
    input wire logic irq_o
);
    int run_reg;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Cycles the stall has lasted; the array strobe comes while the count of the ended stall is still seen.
    always_ff @(posedge clk_i) begin
        run_reg <= cpu_stall_o ? run_reg + 1 : 0;
    end

    a_ack_single_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
    a_start_needs_arm: assert property (
        $rose(cpu_stall_o) |-> ack_o && $past(we_i) && $past(adr_i) == `FWPS_ADDR_CONTROL
        && ($past(dat_i[7:0]) & 8'h26) == 8'h26) else $error("stall began without an armed start");
    a_word_time: assert property (
        flash_we_o |-> run_reg >= TIW_CYCLES - 1 && run_reg <= TIW_CYCLES + 1) else $error("bad stall length");
    a_we_single: assert property (flash_we_o |=> !flash_we_o) else $error("array strobe too long");
    a_addr_held: assert property (
        cpu_stall_o && $past(cpu_stall_o) |-> $stable(flash_addr_o)) else $error("address moved in write");
    a_read_upper_zero: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
    a_abort_stops: assert property (
        $rose(master_clear_reset_i) && cpu_stall_o |-> ##[1:4] !cpu_stall_o) else $error("write not aborted");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !ack_o && !cpu_stall_o && !flash_we_o && !irq_o) else $error("output active in reset");

    c_word_written: cover property (flash_we_o);
    c_stall_begun: cover property ($rose(cpu_stall_o));
    c_irq_cleared: cover property ($fell(irq_o));
endmodule

bind fwps_sequencer fwps_sequencer_assertions #(.TIW_CYCLES(TIW_CYCLES)) u_chk (.*);

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "fwps_cfg.svh"

module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic master_clear_reset_i = 1'b0;
    logic wdt_rst_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [5:0] adr_i = 6'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic flash_we_o;
    logic cpu_stall_o;
    logic irq_o;
    logic [20:0] flash_addr_o;
    logic [15:0] flash_data_o;
    logic [15:0] rd_q[$];
    logic [36:0] fl_q[$];
    logic [15:0] note;
    logic [8:0] refuse_tbl [4] = '{9'h102, 9'h122, 9'h106, 9'h026};
    logic [20:0] ptr;
    logic [7:0] d0;
    logic [7:0] d1;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    fwps_sequencer #(.TIW_CYCLES(20)) DUT (.*);

    always #20 clk_i = ~clk_i;

    task automatic chk(input string what, input logic [36:0] exp, input logic [36:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Results are judged here as they appear, against the notes left by the driver.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 6000) begin
            fail_count++;
            final_report();
        end
        if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0) begin
            note = rd_q.pop_front();
            chk("read data", note[7:0], dat_o[7:0] & note[15:8]);
        end
        if (flash_we_o === 1'b1) begin
            if (fl_q.size() == 0) chk("unexpected array write", 1'b0, 1'b1);
            else chk("array word", fl_q.pop_front(), {flash_addr_o, flash_data_o});
        end
    end

    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
        rd_q.push_back({m, e & m});
        wb(1'b0, a, 8'h00);
    endtask

    task automatic arm(input logic [7:0] ctrl, input logic swap);
        // The enables go in first: a start write that also sets them finds them clear and is refused.
        wb(1'b1, `FWPS_ADDR_CONTROL, ctrl & 8'hfd);
        wb(1'b1, `FWPS_ADDR_UNLOCK, swap ? `FWPS_KEY2 : `FWPS_KEY1);
        wb(1'b1, `FWPS_ADDR_UNLOCK, swap ? `FWPS_KEY1 : `FWPS_KEY2);
        wb(1'b1, `FWPS_ADDR_CONTROL, ctrl);
    endtask

    task automatic settle();
        int n;
        n = 0;
        while (cpu_stall_o !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        repeat (3) @(posedge clk_i);
    endtask

    initial begin
        void'($urandom(32'he9ffee96));
        ptr = 21'($urandom() & 32'h1ffffe);
        d0 = 8'($urandom());
        d1 = 8'($urandom());
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, `FWPS_ADDR_PTR_UPPER, {3'h0, ptr[20:16]});
        wb(1'b1, `FWPS_ADDR_PTR_HIGH, ptr[15:8]);
        wb(1'b1, `FWPS_ADDR_PTR_LOW, ptr[7:0]);
        rd(`FWPS_ADDR_PTR_UPPER, 8'h1f, {3'h0, ptr[20:16]});
        rd(`FWPS_ADDR_PTR_HIGH, 8'hff, ptr[15:8]);
        rd(`FWPS_ADDR_PTR_LOW, 8'hff, ptr[7:0]);
        rd(6'h3c, 8'hff, 8'h00);
        rd(`FWPS_ADDR_UNLOCK, 8'hff, 8'h00);
        $display("test registers done");
        wb(1'b1, `FWPS_ADDR_MASK, 8'h01);
        wb(1'b1, `FWPS_ADDR_LATCH, d0);
        wb(1'b1, `FWPS_ADDR_TABLE_WRITE, 8'h01);
        wb(1'b1, `FWPS_ADDR_LATCH, d1);
        wb(1'b1, `FWPS_ADDR_TABLE_WRITE, 8'h00);
        rd(`FWPS_ADDR_HOLD, 8'hff, d0);
        fl_q.push_back({ptr, d1, d0});
        wb(1'b1, `FWPS_ADDR_IRQ_CTRL, 8'h00);
        arm(8'h26, 1'b0);
        chk("stall", 1'b1, cpu_stall_o);
        settle();
        chk("irq set", 1'b1, irq_o);
        wb(1'b1, `FWPS_ADDR_IRQ_CTRL, 8'h80);
        rd(`FWPS_ADDR_IRQ_CTRL, 8'hff, 8'h80);
        rd(`FWPS_ADDR_CONTROL, 8'h3e, 8'h24);
        rd(`FWPS_ADDR_STATUS, 8'h03, 8'h01);
        repeat (2) @(posedge clk_i);
        chk("irq clear", 1'b0, irq_o);
        wb(1'b1, `FWPS_ADDR_CONTROL, 8'h00);
        $display("test word program done");
        foreach (refuse_tbl[i]) begin
            // Entries without bit 8 send the key bytes in the wrong order, with both enables set.
            arm(refuse_tbl[i][7:0], !refuse_tbl[i][8]);
            chk("refused stall", 1'b0, cpu_stall_o);
            rd(`FWPS_ADDR_STATUS, 8'h03, 8'h02);
        end
        $display("test refusals done");
        for (int i = 0; i < 2; i++) begin
            arm(8'h26, 1'b0);
            rd(`FWPS_ADDR_CONTROL, 8'h02, 8'h02);
            repeat (5) @(posedge clk_i);
            if (i == 0) master_clear_reset_i <= 1'b1;
            else wdt_rst_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            master_clear_reset_i <= 1'b0;
            wdt_rst_i <= 1'b0;
            settle();
            rd(`FWPS_ADDR_CONTROL, 8'h08, 8'h08);
            wb(1'b1, `FWPS_ADDR_CONTROL, 8'h00);
            rd(`FWPS_ADDR_CONTROL, 8'h08, 8'h00);
        end
        $display("test aborted write done");
        final_report();
    end
endmodule
